// ---- hdl/sfg_defs.svh ----
// Overview of operation
// R1: Semaphore irq line high while written flag set
// R2: Host nibble write sets flag; write-one clears
// R3: Memory bus writes only while write allow set
// R4: Error response field selects protected-access answer
// R5: Error irq line high while any error flag
// R6: Write to write-protected address sets write error
// R7: Read from read-protected address sets read error
// R8: Controller writes upper nibble, host lower nibble
// R9: Semaphore cleared by host-domain reset only
// R10: One semaphore store seen by both sides
// R11: Read allowed only if both protections clear
// R12: Low override bit i covers 8K block
// R13: Override bits 2..63 cover 64K blocks
// R14: Override bit set blocks reads regardless
// R15: All override bits reset to zero
// R16: Some override bits may be read-only
// R17: These registers reachable by controller only
// R18: Two lowest 64K override bits read zero
`ifndef SFG_DEFS_SVH
`define SFG_DEFS_SVH

// Register indices; byte address is four times the index
`define SFG_IDX_CTRL 8'h20
`define SFG_IDX_SEMA 8'h22
`define SFG_IDX_ORP_LOW0 8'h23
`define SFG_IDX_ORP_LOW1 8'h24
`define SFG_IDX_ORP_B2 8'h25
`define SFG_IDX_ORP_B8 8'h26
`define SFG_IDX_ORP_B16 8'h27
`define SFG_IDX_ORP_B24 8'h28
`define SFG_IDX_ORP_B32 8'h11
`define SFG_IDX_ORP_B40 8'h12
`define SFG_IDX_ORP_B48 8'h13
`define SFG_IDX_ORP_B56 8'h14
`define SFG_IDX_IRQ_STAT 8'h30
`define SFG_IDX_IRQ_MASK 8'h31

// Control/status fields
`define SFG_CTRL_SEMA_IE 7
`define SFG_CTRL_HSW 6
`define SFG_CTRL_HWA 5
`define SFG_CTRL_ERS_HI 4
`define SFG_CTRL_ERS_LO 3
`define SFG_CTRL_HEIE 2
`define SFG_CTRL_HWE 1
`define SFG_CTRL_HRE 0

// Interrupt status fields
`define SFG_EV_SEMA 0
`define SFG_EV_RERR 1
`define SFG_EV_WERR 2

// Reset values
`define SFG_CTRL_RST 8'h00
`define SFG_SEMA_RST 8'h00
`define SFG_ORP_RST 8'h00
`define SFG_IRQ_RST 3'h0

// Address map of the flash window
`define SFG_ORP_SLOTS 10
`define SFG_ORP_NONE 4'hf
`define SFG_ORP_B2_SLOT 4'h2
`define SFG_LOW_LSB 13
`define SFG_BLK_LSB 16
`define SFG_LOW_AREA_LSB 17

`endif

// ---- hdl/sfg_pkg.sv ----
`default_nettype none
package sfg_pkg;
  // Answer given to one host flash access
  typedef enum logic [2:0] {
    SFG_RESP_OK = 3'h0,
    SFG_RESP_ZERO = 3'h1,
    SFG_RESP_LONG_WAIT = 3'h2,
    SFG_RESP_ERR_SYNC = 3'h3,
    SFG_RESP_IGNORED = 3'h4
  } sfg_resp_t;
  typedef enum logic [1:0] {
    SFG_ERS_WAIT_IGN = 2'h0,
    SFG_ERS_ZERO_IGN = 2'h1,
    SFG_ERS_ERR_ERR = 2'h2,
    SFG_ERS_WAIT_ERR = 2'h3
  } sfg_ers_t;
endpackage : sfg_pkg
`default_nettype wire

// ---- hdl/sfg_sync3.sv ----
`default_nettype none
module sfg_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and control
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Level
  input wire logic async_in,
  output logic level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else if (ce_in) begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once two stages agree
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      level_out <= RST_VAL;
    end else if (ce_in && (s2_reg == s3_reg)) begin
      level_out <= s3_reg;
    end
  end
endmodule : sfg_sync3
`default_nettype wire

// ---- hdl/sfg_ovr_lookup.sv ----
`default_nettype none
`include "sfg_defs.svh"
module sfg_ovr_lookup (
  // Flash address
  input wire logic [21:0] addr_in,
  // Override bits
  input wire logic [15:0] low_bits_in,
  input wire logic [63:0] blk_bits_in,
  // Selected bit
  output logic blocked_out
);
  always_comb begin
    if (addr_in[21:`SFG_LOW_AREA_LSB] == 5'h00) begin
      blocked_out = low_bits_in[addr_in[16:`SFG_LOW_LSB]]; // R12
    end else begin
      blocked_out = blk_bits_in[addr_in[21:`SFG_BLK_LSB]]; // R13
    end
  end
endmodule : sfg_ovr_lookup
`default_nettype wire

// ---- hdl/sfg_host_guard.sv ----
// Implementation choice: register access over AXI4-Lite.
`default_nettype none
`include "sfg_defs.svh"
module sfg_host_guard (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Host side
  input wire logic host_rst_n_in,
  input wire logic host_req_valid_in,
  input wire logic host_req_write_in,
  input wire logic [21:0] host_req_addr_in,
  input wire logic [7:0] host_req_wdata_in,
  input wire logic host_read_protect_in,
  input wire logic host_write_protect_in,
  input wire logic host_sema_wr_in,
  input wire logic [3:0] host_sema_data_in,
  output logic host_resp_valid_out,
  output logic [2:0] host_resp_kind_out,
  output logic [7:0] host_sema_out,
  // Override lock straps, one bit per override bit
  input wire logic [79:0] ovr_lock_in,
  // Internal memory bus
  output logic mbus_wr_out,
  output logic mbus_rd_out,
  output logic [21:0] mbus_addr_out,
  output logic [7:0] mbus_wdata_out,
  // Interrupts
  output logic irq_sema_out,
  output logic irq_err_out,
  output logic irq_out
);
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // AXI write side
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] wr_idx_reg;
  logic [7:0] wr_data_reg;
  logic wr_lane_reg;
  logic do_write;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [7:0] rd_idx;
  logic [3:0] wr_slot;
  // Register state
  logic [7:0] ctrl_reg;
  logic hsw_reg;
  logic hwe_reg;
  logic hre_reg;
  logic [7:0] sema_reg;
  logic [7:0] orp_reg [0:`SFG_ORP_SLOTS-1];
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  // Host side decisions
  logic host_rst_lvl;
  logic ovr_blocked;
  logic rd_err_ev;
  logic wr_err_ev;
  logic sema_ev;
  logic [15:0] low_bits;
  logic [63:0] blk_bits;
  logic [7:0] rd_byte;
  sfg_pkg::sfg_ers_t ers;

  // Decoding shared by reads and writes
  function automatic logic [3:0] ovr_slot(input logic [7:0] idx);
    unique case (idx)
      `SFG_IDX_ORP_LOW0: ovr_slot = 4'h0;
      `SFG_IDX_ORP_LOW1: ovr_slot = 4'h1;
      `SFG_IDX_ORP_B2: ovr_slot = 4'h2;
      `SFG_IDX_ORP_B8: ovr_slot = 4'h3;
      `SFG_IDX_ORP_B16: ovr_slot = 4'h4;
      `SFG_IDX_ORP_B24: ovr_slot = 4'h5;
      `SFG_IDX_ORP_B32: ovr_slot = 4'h6;
      `SFG_IDX_ORP_B40: ovr_slot = 4'h7;
      `SFG_IDX_ORP_B48: ovr_slot = 4'h8;
      `SFG_IDX_ORP_B56: ovr_slot = 4'h9;
      default: ovr_slot = `SFG_ORP_NONE;
    endcase
  endfunction : ovr_slot

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (ovr_slot(idx) != `SFG_ORP_NONE) || (idx == `SFG_IDX_CTRL) ||
                (idx == `SFG_IDX_SEMA) || (idx == `SFG_IDX_IRQ_STAT) ||
                (idx == `SFG_IDX_IRQ_MASK);
  endfunction : is_mapped

  assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
  assign w_hs = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid_out;
  assign rd_idx = s_axi_araddr_in[9:2];
  assign wr_slot = ovr_slot(wr_idx_reg);
  assign ers = sfg_pkg::sfg_ers_t'(ctrl_reg[`SFG_CTRL_ERS_HI:`SFG_CTRL_ERS_LO]);

  // Write address and data are taken in either order; response follows both
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= AXI_OKAY;
      wr_idx_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      wr_lane_reg <= 1'b0;
    end else if (ce_in) begin
      if (aw_hs) begin
        aw_full_reg <= 1'b1;
        s_axi_awready_out <= 1'b0;
        wr_idx_reg <= s_axi_awaddr_in[9:2];
      end
      if (w_hs) begin
        w_full_reg <= 1'b1;
        s_axi_wready_out <= 1'b0;
        wr_data_reg <= s_axi_wdata_in[7:0];
        wr_lane_reg <= s_axi_wstrb_in[0];
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= is_mapped(wr_idx_reg) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // Read mux; upper bits of the word read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (ovr_slot(rd_idx) != `SFG_ORP_NONE) begin
      rd_byte = orp_reg[ovr_slot(rd_idx)];
    end else if (rd_idx == `SFG_IDX_CTRL) begin
      rd_byte = ctrl_reg;
      rd_byte[`SFG_CTRL_HSW] = hsw_reg;
      rd_byte[`SFG_CTRL_HWE] = hwe_reg;
      rd_byte[`SFG_CTRL_HRE] = hre_reg;
    end else if (rd_idx == `SFG_IDX_SEMA) begin
      rd_byte = sema_reg; // R10
    end else if (rd_idx == `SFG_IDX_IRQ_STAT) begin
      rd_byte = {5'h00, irq_stat_reg};
    end else if (rd_idx == `SFG_IDX_IRQ_MASK) begin
      rd_byte = {5'h00, irq_mask_reg};
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= AXI_OKAY;
    end else if (ce_in) begin
      if (ar_hs) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= {24'h00_0000, rd_byte};
        s_axi_rresp_out <= is_mapped(rd_idx) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // Control fields written by the controller; flags live apart
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= `SFG_CTRL_RST;
    end else if (ce_in && do_write && wr_lane_reg && wr_idx_reg == `SFG_IDX_CTRL) begin
      ctrl_reg <= wr_data_reg & 8'hbc;
    end
  end

  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      hsw_reg <= 1'b0;
      hwe_reg <= 1'b0;
      hre_reg <= 1'b0;
    end else if (ce_in) begin
      if (do_write && wr_lane_reg && wr_idx_reg == `SFG_IDX_CTRL) begin
        if (wr_data_reg[`SFG_CTRL_HSW]) hsw_reg <= 1'b0; // R2
        if (wr_data_reg[`SFG_CTRL_HWE]) hwe_reg <= 1'b0; // R6
        if (wr_data_reg[`SFG_CTRL_HRE]) hre_reg <= 1'b0; // R7
      end
      if (sema_ev) hsw_reg <= 1'b1; // R2
      if (wr_err_ev) hwe_reg <= 1'b1; // R6
      if (rd_err_ev) hre_reg <= 1'b1; // R7
    end
  end

  // Host reset arrives from another domain
  sfg_sync3 #(
    .RST_VAL(1'b1)
  ) u_host_rst_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .async_in(host_rst_n_in),
    .level_out(host_rst_lvl)
  );

  // Semaphore is not touched by the controller reset
  always_ff @(posedge mclk_in) begin
    if (ce_in) begin
      if (!host_rst_lvl) begin
        sema_reg <= `SFG_SEMA_RST; // R9
      end else begin
        if (do_write && wr_lane_reg && wr_idx_reg == `SFG_IDX_SEMA) begin
          sema_reg[7:4] <= wr_data_reg[7:4]; // R8
        end
        if (host_sema_wr_in) begin
          sema_reg[3:0] <= host_sema_data_in; // R8
        end
      end
    end
  end

  // Host sees only the semaphore; all other registers stay on the AXI side
  assign sema_ev = ce_in && host_rst_lvl && host_sema_wr_in; // R17
  assign host_sema_out = sema_reg; // R10

  // Override registers with per-bit lock straps
  generate
    for (genvar s = 0; s < `SFG_ORP_SLOTS; s++) begin : g_orp
      logic [7:0] keep_mask;
      assign keep_mask = (s == 2) ? (ovr_lock_in[8*s +: 8] | 8'h03) : ovr_lock_in[8*s +: 8];
      always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
          orp_reg[s] <= `SFG_ORP_RST; // R15
        end else if (ce_in && do_write && wr_lane_reg && wr_slot == 4'(s)) begin
          orp_reg[s] <= (wr_data_reg & ~keep_mask) | (orp_reg[s] & keep_mask); // R16 R18
        end
      end
    end
  endgenerate

  assign low_bits = {orp_reg[1], orp_reg[0]};
  assign blk_bits = {orp_reg[9], orp_reg[8], orp_reg[7], orp_reg[6], orp_reg[5],
                     orp_reg[4], orp_reg[3], orp_reg[2][7:2], 2'h0}; // R18

  sfg_ovr_lookup u_lookup (
    .addr_in(host_req_addr_in),
    .low_bits_in(low_bits),
    .blk_bits_in(blk_bits),
    .blocked_out(ovr_blocked)
  );

  assign rd_err_ev = ce_in && host_req_valid_in && !host_req_write_in &&
                     (host_read_protect_in || ovr_blocked); // R11 R14
  assign wr_err_ev = ce_in && host_req_valid_in && host_req_write_in && host_write_protect_in;

  // One answer per host request, a cycle after it is taken
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      host_resp_valid_out <= 1'b0;
      host_resp_kind_out <= sfg_pkg::SFG_RESP_OK;
      mbus_wr_out <= 1'b0;
      mbus_rd_out <= 1'b0;
      mbus_addr_out <= 22'h00_0000;
      mbus_wdata_out <= 8'h00;
    end else if (ce_in) begin
      host_resp_valid_out <= host_req_valid_in;
      mbus_wr_out <= 1'b0;
      mbus_rd_out <= 1'b0;
      if (host_req_valid_in) begin
        mbus_addr_out <= host_req_addr_in;
        mbus_wdata_out <= host_req_wdata_in;
        if (rd_err_ev) begin
          unique case (ers) // R4
            sfg_pkg::SFG_ERS_ZERO_IGN: host_resp_kind_out <= sfg_pkg::SFG_RESP_ZERO;
            sfg_pkg::SFG_ERS_ERR_ERR: host_resp_kind_out <= sfg_pkg::SFG_RESP_ERR_SYNC;
            default: host_resp_kind_out <= sfg_pkg::SFG_RESP_LONG_WAIT;
          endcase
        end else if (wr_err_ev) begin
          if (ers[1]) begin // R4
            host_resp_kind_out <= sfg_pkg::SFG_RESP_ERR_SYNC;
          end else begin
            host_resp_kind_out <= sfg_pkg::SFG_RESP_IGNORED;
          end
        end else if (host_req_write_in) begin
          // Unprotected write is dropped, not errored, while writes are barred
          if (ctrl_reg[`SFG_CTRL_HWA]) begin
            mbus_wr_out <= 1'b1; // R3
            host_resp_kind_out <= sfg_pkg::SFG_RESP_OK;
          end else begin
            host_resp_kind_out <= sfg_pkg::SFG_RESP_IGNORED; // R3
          end
        end else begin
          mbus_rd_out <= 1'b1; // R11
          host_resp_kind_out <= sfg_pkg::SFG_RESP_OK;
        end
      end
    end
  end

  // Sticky event status with write-one clear; set wins
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      irq_stat_reg <= `SFG_IRQ_RST;
      irq_mask_reg <= `SFG_IRQ_RST;
    end else if (ce_in) begin
      if (do_write && wr_lane_reg && wr_idx_reg == `SFG_IDX_IRQ_MASK) begin
        irq_mask_reg <= wr_data_reg[2:0];
      end
      irq_stat_reg <= (irq_stat_reg &
                       ~((do_write && wr_lane_reg && wr_idx_reg == `SFG_IDX_IRQ_STAT) ?
                         wr_data_reg[2:0] : 3'h0)) |
                      {wr_err_ev, rd_err_ev, sema_ev};
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      irq_sema_out <= 1'b0;
      irq_err_out <= 1'b0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_sema_out <= ctrl_reg[`SFG_CTRL_SEMA_IE] && hsw_reg; // R1
      irq_err_out <= ctrl_reg[`SFG_CTRL_HEIE] && (hwe_reg || hre_reg); // R5
      irq_out <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule : sfg_host_guard
`default_nettype wire

// ---- sim/sfg_chk.sv ----
`default_nettype none
module sfg_chk (
  // Clock and resets
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic host_rst_n_in,
  // Host side
  input wire logic host_req_valid_in,
  input wire logic host_req_write_in,
  input wire logic [21:0] host_req_addr_in,
  input wire logic host_read_protect_in,
  input wire logic host_write_protect_in,
  input wire logic host_sema_wr_in,
  input wire logic [3:0] host_sema_data_in,
  input wire logic host_resp_valid_out,
  input wire logic [2:0] host_resp_kind_out,
  input wire logic [7:0] host_sema_out,
  // Memory bus
  input wire logic mbus_wr_out,
  input wire logic mbus_rd_out,
  input wire logic [21:0] mbus_addr_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_req;
    host_req_valid_in && ce_in;
  endsequence
  // Host reset sync needs a few edges before host writes land
  sequence s_host_up;
    host_rst_n_in [*5];
  endsequence
  a_resp_pulse: assert property (s_req |=> host_resp_valid_out)
    else $error("host request not answered");
  a_sema_low: assert property (s_host_up ##0 host_sema_wr_in && ce_in |=>
    host_sema_out[3:0] == $past(host_sema_data_in)) else $error("host nibble lost");
  // Sync chain plus the clearing edge take five edges; eight leaves margin after reset
  a_host_rst_clr: assert property (!host_rst_n_in [*8] |-> host_sema_out == 8'h00)
    else $error("semaphore kept in host reset");
  a_rd_blocked: assert property (s_req ##0 !host_req_write_in && host_read_protect_in |=>
    !mbus_rd_out && host_resp_kind_out != sfg_pkg::SFG_RESP_OK) else $error("read leaked");
  a_wr_blocked: assert property (s_req ##0 host_req_write_in && host_write_protect_in |=>
    !mbus_wr_out && host_resp_kind_out inside {sfg_pkg::SFG_RESP_IGNORED,
    sfg_pkg::SFG_RESP_ERR_SYNC}) else $error("write leaked");
  a_rd_answer: assert property (s_req ##0 !host_req_write_in |=>
    host_resp_kind_out != sfg_pkg::SFG_RESP_IGNORED && !mbus_wr_out)
    else $error("read answered as write");
  a_wr_source: assert property (mbus_wr_out |-> $past(host_req_valid_in && host_req_write_in
    && !host_write_protect_in) && mbus_addr_out == $past(host_req_addr_in))
    else $error("stray bus write");
  a_rd_source: assert property (mbus_rd_out |-> $past(host_req_valid_in &&
    !host_req_write_in && !host_read_protect_in)) else $error("stray bus read");
endmodule : sfg_chk
`default_nettype wire

// ---- sim/sfg_host_model.sv ----
`default_nettype none
module sfg_host_model (
  // Clock
  input wire logic mclk_in,
  // Host requests
  output logic host_rst_n_out,
  output logic req_valid_out,
  output logic req_write_out,
  output logic [21:0] req_addr_out,
  output logic [7:0] req_wdata_out,
  output logic rprot_out,
  output logic wprot_out,
  // Semaphore lower nibble
  output logic sema_wr_out,
  output logic [3:0] sema_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {req_valid_out, req_write_out, rprot_out, wprot_out, sema_wr_out} = 5'h00;
    req_addr_out = 22'h3fffff;
    req_wdata_out = 8'hff;
    sema_data_out = 4'hf;
    host_rst_n_out = 1'b0;
    // Held past the controller reset, which would otherwise mask it in the sync chain
    repeat (16) @(posedge mclk_in);
    host_rst_n_out <= 1'b1;
  end
  task automatic access(input logic w, input logic [21:0] a, input logic rp, input logic wp);
    @(posedge mclk_in);
    req_valid_out <= 1'b1;
    req_write_out <= w;
    req_addr_out <= a;
    req_wdata_out <= a[7:0];
    rprot_out <= rp;
    wprot_out <= wp;
    @(posedge mclk_in);
    // Released address and data go inverse so stale values never look live
    req_valid_out <= 1'b0;
    req_addr_out <= ~a;
    req_wdata_out <= ~a[7:0];
    @(negedge mclk_in);
  endtask : access
  task automatic sema(input logic [3:0] d);
    @(posedge mclk_in);
    sema_wr_out <= 1'b1;
    sema_data_out <= d;
    @(posedge mclk_in);
    sema_wr_out <= 1'b0;
    sema_data_out <= ~d;
  endtask : sema
  task automatic hreset;
    @(posedge mclk_in);
    host_rst_n_out <= 1'b0;
    repeat (8) @(posedge mclk_in);
    host_rst_n_out <= 1'b1;
    repeat (5) @(posedge mclk_in);
  endtask : hreset
endmodule : sfg_host_model
`default_nettype wire

// ---- sim/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] c;
    logic w;
    logic rp;
    logic wp;
    logic [21:0] a;
    logic [2:0] k;
    logic m;
  } sfg_row_t;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic [11:0] s_axi_awaddr_in = 12'h000;
  logic [11:0] s_axi_araddr_in = 12'h000;
  logic [31:0] s_axi_wdata_in = 32'h00000000;
  logic [3:0] s_axi_wstrb_in = 4'h1;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic host_rst_n_in, host_req_valid_in, host_req_write_in, host_read_protect_in;
  logic host_write_protect_in, host_sema_wr_in, host_resp_valid_out;
  logic [21:0] host_req_addr_in, mbus_addr_out;
  logic [7:0] host_req_wdata_in, host_sema_out, mbus_wdata_out;
  logic [3:0] host_sema_data_in;
  logic [2:0] host_resp_kind_out;
  logic [79:0] ovr_lock_in = 80'h0;
  logic mbus_wr_out, mbus_rd_out, irq_sema_out, irq_err_out, irq_out;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] regs [14] = '{8'h20, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28,
    8'h11, 8'h12, 8'h13, 8'h14, 8'h30, 8'h31};
  // Overrides set: low bit 3, block bit 2, block bit 39
  sfg_row_t rows [19] = '{
    '{8'h20, 0, 0, 0, 22'h000100, 3'h0, 1}, '{8'h20, 1, 0, 0, 22'h000100, 3'h0, 1},
    '{8'h00, 1, 0, 0, 22'h000100, 3'h4, 0}, '{8'h20, 0, 1, 0, 22'h000100, 3'h2, 0},
    '{8'h28, 0, 1, 0, 22'h000100, 3'h1, 0}, '{8'h30, 0, 1, 0, 22'h000100, 3'h3, 0},
    '{8'h38, 0, 1, 0, 22'h000100, 3'h2, 0}, '{8'h20, 1, 0, 1, 22'h000100, 3'h4, 0},
    '{8'h28, 1, 0, 1, 22'h000100, 3'h4, 0}, '{8'h30, 1, 0, 1, 22'h000100, 3'h3, 0},
    '{8'h38, 1, 0, 1, 22'h000100, 3'h3, 0}, '{8'h30, 0, 0, 0, 22'h007fff, 3'h3, 0},
    '{8'h30, 0, 0, 0, 22'h008000, 3'h0, 1}, '{8'h30, 0, 0, 0, 22'h005fff, 3'h0, 1},
    '{8'h30, 0, 0, 0, 22'h020000, 3'h3, 0}, '{8'h30, 0, 0, 0, 22'h01ffff, 3'h0, 1},
    '{8'h30, 0, 0, 0, 22'h27ffff, 3'h3, 0}, '{8'h30, 0, 0, 0, 22'h280000, 3'h0, 1},
    '{8'h30, 1, 0, 0, 22'h007000, 3'h0, 1}};
  always #25 mclk_in = ~mclk_in;
  sfg_host_guard i_dut (.mclk_in, .rst_n_in, .ce_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .host_rst_n_in,
    .host_req_valid_in, .host_req_write_in, .host_req_addr_in, .host_req_wdata_in,
    .host_read_protect_in, .host_write_protect_in, .host_sema_wr_in, .host_sema_data_in,
    .host_resp_valid_out, .host_resp_kind_out, .host_sema_out, .ovr_lock_in, .mbus_wr_out,
    .mbus_rd_out, .mbus_addr_out, .mbus_wdata_out, .irq_sema_out, .irq_err_out, .irq_out);
  sfg_host_model i_host (.mclk_in, .host_rst_n_out(host_rst_n_in),
    .req_valid_out(host_req_valid_in), .req_write_out(host_req_write_in),
    .req_addr_out(host_req_addr_in), .req_wdata_out(host_req_wdata_in),
    .rprot_out(host_read_protect_in), .wprot_out(host_write_protect_in),
    .sema_wr_out(host_sema_wr_in), .sema_data_out(host_sema_data_in));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic axw(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk_in);
    s_axi_awaddr_in <= {2'b00, i, 2'b00};
    s_axi_wdata_in <= {24'h000000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    while (n < 50) begin
      @(posedge mclk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out) break;
      n++;
    end
    s_axi_bready_in <= 1'b0;
    chk(s_axi_bresp_out, er);
    chk(n < 50, 1);
  endtask : axw
  task automatic axr(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk_in);
    s_axi_araddr_in <= {2'b00, i, 2'b00};
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    while (n < 50) begin
      @(posedge mclk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out) break;
      n++;
    end
    s_axi_rready_in <= 1'b0;
    chk(s_axi_rdata_out, e);
    chk({s_axi_rresp_out, n < 50}, {er, 1'b1});
  endtask : axr
  task automatic settle;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask : settle
  initial begin
    #250us;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    foreach (regs[r]) axr(regs[r], 32'h0, 2'h0);
    axr(8'h3f, 32'h0, 2'h2);
    axw(8'h3f, 8'hff, 2'h2);
    axw(8'h23, 8'h08, 2'h0);
    axw(8'h25, 8'h04, 2'h0);
    axw(8'h11, 8'h80, 2'h0);
    foreach (rows[r]) begin
      axw(8'h20, rows[r].c, 2'h0);
      i_host.access(rows[r].w, rows[r].a, rows[r].rp, rows[r].wp);
      chk({host_resp_valid_out, host_resp_kind_out}, {1'b1, rows[r].k});
      chk(rows[r].w ? mbus_wr_out : mbus_rd_out, rows[r].m);
      chk({mbus_addr_out, mbus_wdata_out}, {rows[r].a, rows[r].a[7:0]});
      axr(8'h20, {rows[r].c[7:2], rows[r].w & rows[r].wp, ~rows[r].w & ~rows[r].m}, 2'h0);
      axw(8'h20, rows[r].c | 8'h03, 2'h0);
    end
    ovr_lock_in <= 80'h1;
    axw(8'h23, 8'hff, 2'h0);
    axr(8'h23, 32'hfe, 2'h0);
    axw(8'h25, 8'hff, 2'h0);
    axr(8'h25, 32'hfc, 2'h0);
    axw(8'h20, 8'h00, 2'h0);
    axr(8'h30, 32'h06, 2'h0);
    axw(8'h30, 8'h07, 2'h0);
    axw(8'h31, 8'h01, 2'h0);
    s_axi_wstrb_in <= 4'h0;
    axw(8'h31, 8'h07, 2'h0);
    s_axi_wstrb_in <= 4'h1;
    axr(8'h31, 32'h01, 2'h0);
    i_host.sema(4'ha);
    axr(8'h22, 32'h0a, 2'h0);
    axr(8'h20, 32'h40, 2'h0);
    chk({irq_sema_out, irq_out}, 2'b01);
    axw(8'h20, 8'h80, 2'h0);
    settle();
    chk(irq_sema_out, 1);
    axw(8'h22, 8'h5f, 2'h0);
    axr(8'h22, 32'h5a, 2'h0);
    chk(host_sema_out, 8'h5a);
    axw(8'h20, 8'hc0, 2'h0);
    settle();
    chk(irq_sema_out, 0);
    axw(8'h30, 8'h01, 2'h0);
    settle();
    chk(irq_out, 0);
    i_host.sema(4'h3);
    settle();
    chk({irq_sema_out, irq_out}, 2'b11);
    axw(8'h20, 8'h04, 2'h0);
    i_host.access(1'b0, 22'h000100, 1'b1, 1'b0);
    settle();
    chk(irq_err_out, 1);
    axw(8'h20, 8'h05, 2'h0);
    settle();
    chk(irq_err_out, 0);
    @(posedge mclk_in);
    ce_in <= 1'b0;
    i_host.access(1'b1, 22'h000100, 1'b0, 1'b0);
    chk(host_resp_valid_out, 0);
    @(posedge mclk_in);
    ce_in <= 1'b1;
    i_host.hreset();
    axr(8'h22, 32'h0, 2'h0);
    i_host.sema(4'h6);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    axr(8'h22, 32'h06, 2'h0);
    axr(8'h20, 32'h0, 2'h0);
    axr(8'h23, 32'h0, 2'h0);
    stop_test();
  end
endmodule : tb
bind sfg_host_guard sfg_chk i_chk (.mclk_in, .rst_n_in, .ce_in, .host_rst_n_in,
  .host_req_valid_in, .host_req_write_in, .host_req_addr_in, .host_read_protect_in,
  .host_write_protect_in, .host_sema_wr_in, .host_sema_data_in, .host_resp_valid_out,
  .host_resp_kind_out, .host_sema_out, .mbus_wr_out, .mbus_rd_out, .mbus_addr_out);
`default_nettype wire
